// file: hw/motor_fault_supervisor.sv
`timescale 1ns/1ps
module motor_fault_supervisor
   import motor_fault_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic loop_tick,
   input wire logic [2:0] high_on,
   input wire logic [2:0] low_on,
   input wire logic [VW-1:0] vds_high [3],
   input wire logic [VW-1:0] vds_low [3],
   input wire logic [1:0] fet_drop_threshold_sel,
   input wire logic short_protect_en,
   input wire logic brake_in_n,
   input wire logic [CW-1:0] speed_command,
   input wire logic [CW-1:0] command_off_level,
   input wire logic [CW-1:0] command_on_level,
   input wire logic [1:0] stall_method_sel,
   input wire logic signed [VW-1:0] est_freq,
   input wire logic [VW-1:0] stall_min_freq,
   input wire logic signed [VW-1:0] est_vq,
   input wire logic signed [VW-1:0] vq_upper_limit,
   input wire logic signed [VW-1:0] vq_lower_limit,
   input wire logic [CW-1:0] vq_excursion_time,
   input wire logic signed [VW-1:0] est_backemf,
   input wire logic signed [VW-1:0] stall_min_backemf,
   input wire logic [3:0] restart_attempt_limit,
   input wire logic [CW-1:0] restart_wait_time,
   input wire logic [CW-1:0] stall_blank_time,
   input wire logic no_motor_detect,
   input wire logic ramp_done,
   input wire logic start_done,
   input wire logic supply_clamp_en,
   input wire logic [VW-1:0] supply_voltage,
   input wire logic [VW-1:0] supply_clamp_level,
   input wire logic [CW-1:0] supply_clamp_command,
   input wire logic [VW-1:0] supply_current,
   input wire logic [VW-1:0] max_current,
   input wire logic [6:0] q_current_cap,
   input wire logic [6:0] power_cap,
   input wire logic [2*VW-1:0] max_power,
   input wire logic signed [VW-1:0] iq_ref_in,
   output logic signed [VW-1:0] iq_ref_out,
   output logic [CW-1:0] motor_command,
   output logic bridge_enable,
   output logic brake_low_side,
   output logic fault_out_n,
   output logic fet_short_fault,
   output logic stall_fault_flag,
   output logic stall_held_flag,
   output logic supply_clamp_mode,
   output logic [2:0] control_mode_word,
   output logic start_request
);
   sup_state_t state_r, state_nxt;
   logic short_r;
   logic stall_flag_r, held_r, clamp_r;
   logic [CW-1:0] vq_cnt_r, wait_cnt_r, blank_cnt_r, cmd_r;
   logic [3:0] tries_r;
   logic [VW-1:0] derate_r;
   logic signed [VW-1:0] iq_r;
   logic blank_done_r;

   logic [VW-1:0] vds_th;
   logic [2:0] hs_trip, ls_trip;
   logic short_hit, cmd_off, cmd_on;
   logic [VW-1:0] abs_freq, abs_bemf, abs_bemf_th;
   logic vq_out, vq_stall, freq_stall, bemf_stall, method_stall;
   logic stall_now, stall_seen, retries_left, wait_over;
   logic [VW+6:0] cap_prod;
   logic [VW-1:0] iq_cap;
   logic [2*VW-1:0] power_now;
   logic [2*VW+6:0] pcap_prod;
   logic [2*VW-1:0] pcap;
   logic over_power;
   logic signed [VW:0] iq_mag;
   logic [VW-1:0] iq_lim;
   logic iq_clip, retry_go, clamp_up, clamp_down;
   logic derate_up, derate_down;
   logic short_nxt, stall_flag_nxt, held_nxt;
   logic brake_meta_r, brake_sync_r;

   assign vds_th = (fet_drop_threshold_sel == 2'h0) ? VDS_TH_0 :
                   (fet_drop_threshold_sel == 2'h1) ? VDS_TH_1 :
                   (fet_drop_threshold_sel == 2'h2) ? VDS_TH_2 :
                   VDS_TH_3;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ph
         assign hs_trip[g] = high_on[g] && (vds_high[g] > vds_th);
         assign ls_trip[g] = low_on[g] && (vds_low[g] > vds_th);
      end
   endgenerate
   assign short_hit = short_protect_en && loop_tick
      && (|hs_trip || |ls_trip);
   assign cmd_off = speed_command < command_off_level;
   assign cmd_on = speed_command > command_on_level;

   assign abs_freq = est_freq[VW-1] ? VW'(-est_freq) : VW'(est_freq);
   assign abs_bemf = est_backemf[VW-1] ? VW'(-est_backemf)
      : VW'(est_backemf);
   assign abs_bemf_th = stall_min_backemf[VW-1] ? VW'(-stall_min_backemf)
      : VW'(stall_min_backemf);
   assign freq_stall = abs_freq < stall_min_freq;
   assign bemf_stall = abs_bemf < abs_bemf_th;
   assign vq_out = (est_vq < vq_lower_limit) || (est_vq > vq_upper_limit);
   assign vq_stall = vq_out && (vq_cnt_r > vq_excursion_time);
   assign method_stall = (stall_method_sel == 2'h1) ? freq_stall :
                         (stall_method_sel == 2'h2) ? vq_stall :
                         (stall_method_sel == 2'h3) ? bemf_stall :
                         1'b0;
   assign stall_now = method_stall || no_motor_detect;
   assign stall_seen = loop_tick && (state_r == ST_CLOSED_LOOP)
      && blank_done_r && stall_now;
   assign retries_left = tries_r < restart_attempt_limit;
   assign wait_over = wait_cnt_r >= restart_wait_time;
   assign retry_go = (state_r == ST_STALL_WAIT)
      && (state_nxt == ST_STALL_RETRY);
   assign clamp_up = supply_voltage > supply_clamp_level;
   assign clamp_down = supply_voltage < supply_clamp_level;
   assign short_nxt = (state_nxt == ST_SHORT);
   assign stall_flag_nxt = (state_nxt == ST_STALL_WAIT)
      || (state_nxt == ST_STALL_RETRY)
      || (state_nxt == ST_STALL_HELD);
   assign held_nxt = (state_nxt == ST_STALL_HELD);

   assign cap_prod = max_current * q_current_cap;
   assign iq_cap = VW'(cap_prod / PCT_FULL);
   assign power_now = supply_voltage * supply_current;
   assign pcap_prod = max_power * power_cap;
   assign pcap = (2*VW)'(pcap_prod / PCT_FULL);
   assign over_power = power_now > pcap;
   assign iq_lim = (iq_cap > derate_r) ? VW'(iq_cap - derate_r) : '0;
   assign iq_mag = iq_ref_in[VW-1] ? -(VW+1)'(iq_ref_in)
      : (VW+1)'(iq_ref_in);
   assign iq_clip = iq_mag > (VW+1)'(iq_lim);
   assign derate_up = over_power && (derate_r < iq_cap);
   assign derate_down = !over_power && (derate_r != '0);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_STANDBY: begin
            if (cmd_on) state_nxt = ST_WINDMILL;
         end
         ST_WINDMILL: begin
            state_nxt = ST_OPEN_LOOP;
         end
         ST_OPEN_LOOP: begin
            if (ramp_done) state_nxt = ST_CLOSED_LOOP;
         end
         ST_CLOSED_LOOP: begin
            if (stall_seen) state_nxt = ST_STALL_WAIT;
            else if (cmd_off) state_nxt = ST_STANDBY;
         end
         ST_STALL_WAIT: begin
            if (!stall_now) state_nxt = ST_STANDBY;
            else if (!retries_left) state_nxt = ST_STALL_HELD;
            else if (wait_over) state_nxt = ST_STALL_RETRY;
         end
         ST_STALL_RETRY: begin
            if (!stall_now) state_nxt = ST_STANDBY;
            else if (start_done) state_nxt = ST_STALL_WAIT;
         end
         ST_STALL_HELD: begin
            if (cmd_off) state_nxt = ST_STANDBY;
         end
         ST_SHORT: begin
            if (cmd_off) state_nxt = ST_STANDBY;
         end
         default: state_nxt = ST_STANDBY;
      endcase
      if (short_hit) state_nxt = ST_SHORT;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= ST_STANDBY;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         short_r <= 1'b0;
         stall_flag_r <= 1'b0;
         held_r <= 1'b0;
      end else begin
         short_r <= short_nxt;
         stall_flag_r <= stall_flag_nxt;
         held_r <= held_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tries_r <= '0;
         wait_cnt_r <= '0;
      end else if (state_r == ST_CLOSED_LOOP || state_r == ST_STANDBY) begin
         tries_r <= '0;
         wait_cnt_r <= '0;
      end else if (state_r == ST_STALL_WAIT) begin
         if (retry_go) begin
            tries_r <= tries_r + 4'h1;
            wait_cnt_r <= '0;
         end else if (loop_tick && !wait_over) begin
            wait_cnt_r <= wait_cnt_r + CW'(DR_STEP);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         vq_cnt_r <= '0;
         blank_cnt_r <= '0;
         blank_done_r <= 1'b0;
      end else if (state_r != ST_CLOSED_LOOP) begin
         vq_cnt_r <= '0;
         blank_cnt_r <= '0;
         blank_done_r <= 1'b0;
      end else if (loop_tick) begin
         if (!vq_out) vq_cnt_r <= '0;
         else if (vq_cnt_r != '1) vq_cnt_r <= vq_cnt_r + CW'(DR_STEP);
         if (blank_cnt_r >= stall_blank_time) blank_done_r <= 1'b1;
         else blank_cnt_r <= blank_cnt_r + CW'(DR_STEP);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clamp_r <= 1'b0;
         cmd_r <= ZERO_CMD;
         derate_r <= '0;
         iq_r <= '0;
      end else if (loop_tick) begin
         if (!supply_clamp_en) clamp_r <= 1'b0;
         else if (clamp_up) clamp_r <= 1'b1;
         else if (clamp_down) clamp_r <= 1'b0;
         cmd_r <= clamp_r ? supply_clamp_command : speed_command;
         if (derate_up) begin
            derate_r <= derate_r + VW'(DR_STEP);
         end else if (derate_down) begin
            derate_r <= derate_r - VW'(DR_STEP);
         end
         if (iq_clip) begin
            iq_r <= iq_ref_in[VW-1] ? -$signed(iq_lim) : $signed(iq_lim);
         end else begin
            iq_r <= iq_ref_in;
         end
      end
   end

   // Brake input is a pin: two flops before use
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         brake_meta_r <= 1'b1;
         brake_sync_r <= 1'b1;
      end else begin
         brake_meta_r <= brake_in_n;
         brake_sync_r <= brake_meta_r;
      end
   end

   assign iq_ref_out = iq_r;
   assign motor_command = cmd_r;
   assign bridge_enable = (state_r == ST_WINDMILL)
      || (state_r == ST_OPEN_LOOP) || (state_r == ST_CLOSED_LOOP)
      || (state_r == ST_STALL_RETRY);
   assign fault_out_n = !(short_r || stall_flag_r);
   assign brake_low_side = short_r && !brake_sync_r;
   assign fet_short_fault = short_r;
   assign stall_fault_flag = stall_flag_r;
   assign stall_held_flag = held_r;
   assign supply_clamp_mode = clamp_r;
   assign control_mode_word = state_r;
   assign start_request = (state_r == ST_STALL_RETRY);
endmodule

// file: hw/motor_fault_pkg.sv
package motor_fault_pkg;
   localparam int VW = 16;
   localparam int CW = 8;
   localparam logic [VW-1:0] VDS_TH_0 = 16'h01F4;
   localparam logic [VW-1:0] VDS_TH_1 = 16'h02EE;
   localparam logic [VW-1:0] VDS_TH_2 = 16'h03E8;
   localparam logic [VW-1:0] VDS_TH_3 = 16'h05DC;
   localparam logic [6:0] PCT_FULL = 7'h64;
   localparam logic [CW-1:0] ZERO_CMD = 8'h00;
   localparam int DR_STEP = 1;
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b000,
      ST_WINDMILL = 3'b001,
      ST_OPEN_LOOP = 3'b010,
      ST_CLOSED_LOOP = 3'b011,
      ST_STALL_WAIT = 3'b100,
      ST_STALL_RETRY = 3'b101,
      ST_STALL_HELD = 3'b110,
      ST_SHORT = 3'b111
   } sup_state_t;
endpackage

// file: sim/motor_fault_supervisor_checker.sv
`timescale 1ns/1ps
module motor_fault_supervisor_checker
   import motor_fault_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic loop_tick,
   input wire logic short_protect_en,
   input wire logic brake_in_n,
   input wire logic [CW-1:0] speed_command,
   input wire logic [CW-1:0] command_off_level,
   input wire logic bridge_enable,
   input wire logic brake_low_side,
   input wire logic fault_out_n,
   input wire logic fet_short_fault,
   input wire logic stall_fault_flag,
   input wire logic [2:0] control_mode_word,
   input wire logic start_request
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence short_rise;
      $rose(fet_short_fault);
   endsequence
   sequence stall_rise;
      $rose(stall_fault_flag);
   endsequence
   short_low_a: assert property (fet_short_fault |-> !fault_out_n)
      else $error("short without fault output");
   short_off_a: assert property (fet_short_fault |-> !bridge_enable)
      else $error("bridge on during short");
   stall_low_a: assert property (stall_fault_flag |-> !fault_out_n)
      else $error("stall without fault output");
   fault_cause_a: assert property (!fault_out_n |->
      fet_short_fault || stall_fault_flag)
      else $error("fault output low without cause");
   brake_path_a: assert property (brake_low_side |->
      fet_short_fault && !$past(brake_in_n, 2))
      else $error("brake without short and brake input");
   short_mask_a: assert property (short_rise |->
      $past(short_protect_en) && $past(loop_tick))
      else $error("short raised while masked or off tick");
   short_latch_a: assert property (fet_short_fault &&
      speed_command >= command_off_level |=> fet_short_fault)
      else $error("short cleared while command on");
   stall_closed_a: assert property (stall_rise |->
      $past(control_mode_word) == ST_CLOSED_LOOP)
      else $error("stall raised outside closed loop");
   retry_drive_a: assert property (start_request |-> bridge_enable)
      else $error("retry without bridge drive");
   stall_off_a: assert property (stall_fault_flag && !start_request
      |-> !bridge_enable)
      else $error("bridge on during stall wait");
endmodule
bind motor_fault_supervisor motor_fault_supervisor_checker chk (.clk_sys,
   .rst_n, .loop_tick, .short_protect_en, .brake_in_n, .speed_command,
   .command_off_level, .bridge_enable, .brake_low_side, .fault_out_n,
   .fet_short_fault, .stall_fault_flag, .control_mode_word, .start_request);

// file: sim/bridge_model.sv
`timescale 1ns/1ps
module bridge_model
   import motor_fault_pkg::*;
(
   input wire logic bridge_enable,
   input wire logic brake_low_side,
   input wire logic [VW-1:0] short_mv,
   output logic [2:0] high_on,
   output logic [2:0] low_on,
   output logic [VW-1:0] vds_high [3],
   output logic [VW-1:0] vds_low [3]
);
   // Braking closes every low side
   assign high_on = bridge_enable ? 3'h5 : 3'h0;
   assign low_on = brake_low_side ? 3'h7 : (bridge_enable ? 3'h2 : 3'h0);
   // Off switches see the full bus, so only on switches may trip
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         vds_high[i] = high_on[i] ? short_mv : 16'hFFFF;
         vds_low[i] = low_on[i] ? short_mv : 16'hFFFF;
      end
   end
endmodule

// file: sim/motor_fault_supervisor_tb_top.sv
`timescale 1ns/1ps
module motor_fault_supervisor_tb_top;
   import motor_fault_pkg::*;
   typedef struct packed {logic [1:0] sel; logic [15:0] mv; logic e;} row_t;
   row_t rows [8] = '{'{2'h0, 16'h01F4, 1'b0}, '{2'h0, 16'h01F5, 1'b1},
      '{2'h1, 16'h02EE, 1'b0}, '{2'h1, 16'h02EF, 1'b1},
      '{2'h2, 16'h03E8, 1'b0}, '{2'h2, 16'h03E9, 1'b1},
      '{2'h3, 16'h05DC, 1'b0}, '{2'h3, 16'h05DD, 1'b1}};
   logic clk_sys = 1'b0, rst_n = 1'b0, loop_tick = 1'b0, brake_wired = 1'b0;
   logic short_protect_en = 1'b1, supply_clamp_en = 1'b0, ramp_done = 1'b1;
   logic no_motor_detect = 1'b0, start_done = 1'b1, brake_in_n;
   logic [1:0] fet_drop_threshold_sel = 2'h0, stall_method_sel = 2'h1;
   logic [CW-1:0] speed_command = 8'h80, command_off_level = 8'h10;
   logic [CW-1:0] command_on_level = 8'h20, vq_excursion_time = 8'h02;
   logic [CW-1:0] restart_wait_time = 8'h01, stall_blank_time = 8'h02;
   logic [CW-1:0] supply_clamp_command = 8'h33, motor_command;
   logic [3:0] restart_attempt_limit = 4'h1;
   logic signed [VW-1:0] est_freq = 16'h01F4, est_backemf = 16'h01F4;
   logic signed [VW-1:0] est_vq = 16'h0000, vq_upper_limit = 16'h0100;
   logic signed [VW-1:0] vq_lower_limit = 16'hFF00, iq_ref_in = 16'h1000;
   logic signed [VW-1:0] stall_min_backemf = 16'h0064, iq_ref_out;
   logic [VW-1:0] stall_min_freq = 16'h0064, supply_voltage = 16'h0032;
   logic [VW-1:0] supply_clamp_level = 16'h0064, supply_current = 16'h0001;
   logic [VW-1:0] max_current = 16'h03E8, short_mv = 16'h0000;
   logic [VW-1:0] vds_high [3], vds_low [3];
   logic [6:0] q_current_cap = 7'h32, power_cap = 7'h64;
   logic [2*VW-1:0] max_power = 32'hFFFFFFFF;
   logic [2:0] high_on, low_on, control_mode_word;
   logic bridge_enable, brake_low_side, fault_out_n, fet_short_fault;
   logic stall_fault_flag, stall_held_flag, supply_clamp_mode, start_request;
   int num_errors = 0, compares = 0, i;
   always #5 clk_sys = ~clk_sys;
   assign brake_in_n = brake_wired ? fault_out_n : 1'b1;
   motor_fault_supervisor uut (.clk_sys, .rst_n, .loop_tick, .high_on,
      .low_on, .vds_high, .vds_low, .fet_drop_threshold_sel, .short_protect_en,
      .brake_in_n, .speed_command, .command_off_level, .command_on_level,
      .stall_method_sel, .est_freq, .stall_min_freq, .est_vq, .vq_upper_limit,
      .vq_lower_limit, .vq_excursion_time, .est_backemf, .stall_min_backemf,
      .restart_attempt_limit, .restart_wait_time, .stall_blank_time,
      .no_motor_detect, .ramp_done, .start_done, .supply_clamp_en,
      .supply_voltage, .supply_clamp_level, .supply_clamp_command,
      .supply_current, .max_current, .q_current_cap, .power_cap, .max_power,
      .iq_ref_in, .iq_ref_out, .motor_command, .bridge_enable, .brake_low_side,
      .fault_out_n, .fet_short_fault, .stall_fault_flag, .stall_held_flag,
      .supply_clamp_mode, .control_mode_word, .start_request);
   bridge_model far (.bridge_enable, .brake_low_side, .short_mv, .high_on,
      .low_on, .vds_high, .vds_low);
   task check(input string n, input logic [VW-1:0] e, g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task tick(input int n);
      repeat (n) begin
         @(negedge clk_sys) loop_tick = 1'b1;
         @(negedge clk_sys) loop_tick = 1'b0;
      end
   endtask
   task tally_and_finish;
      $display("Compares %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task until_state(input logic [2:0] st);
      for (i = 0; i < 40 && control_mode_word !== st; i++)
         tick(1);
      check("control_mode_word", st, control_mode_word);
      if (i == 40)
         tally_and_finish();
   endtask
   initial begin
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      for (int r = 0; r < 8; r++) begin
         @(negedge clk_sys) rst_n = 1'b0;
         short_mv = 16'h0000;
         fet_drop_threshold_sel = rows[r].sel;
         @(negedge clk_sys) rst_n = 1'b1;
         until_state(ST_CLOSED_LOOP);
         short_mv = rows[r].mv;
         tick(1);
         check("fet_short_fault", rows[r].e, fet_short_fault);
         check("fault_out_n", !rows[r].e, fault_out_n);
         $display("Threshold row %0d done", r);
      end
      short_protect_en = 1'b0;
      brake_wired = 1'b1;
      tick(2);
      check("fet_short_fault", 1'b1, fet_short_fault);
      check("brake_low_side", 1'b1, brake_low_side);
      speed_command = 8'h00;
      short_mv = 16'h05DD;
      tick(2);
      speed_command = 8'h80;
      until_state(ST_CLOSED_LOOP);
      tick(2);
      check("fet_short_fault", 1'b0, fet_short_fault);
      short_protect_en = 1'b1;
      short_mv = 16'h0000;
      brake_wired = 1'b0;
      $display("Short latch test done");
      est_freq = 16'hFFF6;
      tick(2);
      check("stall_fault_flag", 1'b1, stall_fault_flag);
      check("bridge_enable", 1'b0, bridge_enable);
      est_freq = 16'h01F4;
      speed_command = 8'h18;
      until_state(ST_STANDBY);
      check("stall_fault_flag", 1'b0, stall_fault_flag);
      speed_command = 8'h80;
      stall_method_sel = 2'h3;
      until_state(ST_CLOSED_LOOP);
      est_backemf = 16'hFFF0;
      for (i = 0; i < 80 && stall_held_flag !== 1'b1; i++)
         tick(1);
      check("stall_held_flag", 1'b1, stall_held_flag);
      speed_command = 8'h00;
      tick(2);
      check("stall_held_flag", 1'b0, stall_held_flag);
      $display("Stall retry test done");
      est_backemf = 16'h01F4;
      speed_command = 8'h80;
      supply_clamp_en = 1'b1;
      supply_voltage = 16'h00C8;
      until_state(ST_CLOSED_LOOP);
      tick(2);
      check("supply_clamp_mode", 1'b1, supply_clamp_mode);
      check("motor_command", 8'h33, motor_command);
      check("fault_out_n", 1'b1, fault_out_n);
      check("iq_ref_out", 16'h01F4, iq_ref_out);
      supply_voltage = 16'h0032;
      tick(2);
      check("supply_clamp_mode", 1'b0, supply_clamp_mode);
      $display("Limiter test done");
      tally_and_finish();
   end
endmodule
